// file: hw/hsbs_pkg.sv
// Constants, encodings and boot stage codes for the hub strap and boot sequencer.
// Assumes a single 200 MHz reference clock and an asynchronous active-low reset.
package hsbs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PORTS      = 7;
  localparam int NUM_GPIO   = 28;
  localparam int SYNC_DEPTH = 2;
  localparam int SYNC_W     = 57;

  // ----------------------------------------------------------------
  // Resistor-sense codes, shared by all three six-way straps
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_200K_PD = 3'h0;
  localparam logic [2:0] CODE_200K_PU = 3'h1;
  localparam logic [2:0] CODE_10K_PD  = 3'h2;
  localparam logic [2:0] CODE_10K_PU  = 3'h3;
  localparam logic [2:0] CODE_10R_PD  = 3'h4;
  localparam logic [2:0] CODE_10R_PU  = 3'h5;

  // Mode strap settings.
  localparam logic [2:0] indicators_no_sideband_setting    = CODE_200K_PD;
  localparam logic [2:0] indicators_sideband_slave_setting = CODE_200K_PU;
  localparam logic [2:0] charge_indicator_setting          = CODE_10R_PD;

  // Port masks selected by the count straps.
  localparam logic [6:0] MASK_NONE = 7'h00;
  localparam logic [6:0] MASK_P1   = 7'h01;
  localparam logic [6:0] MASK_P12  = 7'h03;
  localparam logic [6:0] MASK_P13  = 7'h07;
  localparam logic [6:0] MASK_P14  = 7'h0f;
  localparam logic [6:0] MASK_P17  = 7'h7f;

  // ----------------------------------------------------------------
  // Internal ROM defaults, loaded before the straps override them
  // ----------------------------------------------------------------
  localparam logic [6:0] DEF_PORT_DISABLE = 7'h00;
  localparam logic [6:0] DEF_FIXED_MASK   = 7'h00;
  localparam logic [6:0] DEF_CHARGE_MASK  = 7'h00;

  // ----------------------------------------------------------------
  // Serial ROM probe
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ       = 200;
  localparam int          SPI_SCLK_MHZ  = 50;
  localparam int          SPI_HALF_CYC  = (CLK_MHZ + 2 * SPI_SCLK_MHZ - 1) / (2 * SPI_SCLK_MHZ);
  localparam logic [7:0]  SPI_CMD_READ  = 8'h03;
  localparam logic [7:0]  SPI_CMD_DUAL  = 8'h3b;
  localparam logic [23:0] SPI_SIG_ADDR  = 24'h00fffa;
  localparam logic [23:0] SPI_EXEC_ADDR = 24'h000000;
  localparam logic [31:0] SPI_SIGNATURE = 32'h32444655;
  localparam logic [6:0]  SPI_HDR_CLKS  = 7'h20;
  localparam logic [6:0]  SPI_DUMMY     = 7'h08;
  localparam logic [6:0]  SPI_DATA_1B   = 7'h20;
  localparam logic [6:0]  SPI_DATA_2B   = 7'h10;

  // ----------------------------------------------------------------
  // Sideband register that ends the SoC configuration stage
  // ----------------------------------------------------------------
  localparam logic [7:0] SOC_DONE_REG = 8'hff;

  // ----------------------------------------------------------------
  // Boot stages
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_INIT    = 10'h001,
    ST_PROBE   = 10'h002,
    ST_EXT     = 10'h004,
    ST_CFG_RD  = 10'h008,
    ST_STRAP   = 10'h010,
    ST_SOC_CFG = 10'h020,
    ST_MERGE   = 10'h040,
    ST_IDLE    = 10'h080,
    ST_CHARGER_DETECT_STAGE  = 10'h100,
    ST_CONNECT = 10'h200
  } hsbs_state_t;

endpackage

// file: hw/hsbs_sync.sv
// Two-stage synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; multi-bit coherence is not guaranteed.
`timescale 1ns/1ps
module hsbs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// file: hw/hsbs_top.sv
// Strap capture, pin function decode and boot stage sequencing for a seven-port hub.
// Assumes resistor-sense front ends present each six-way strap as a 3-bit code, and the
// sideband slave and charger detector live outside and talk on the same clock.
//
// Behaviour
// - Latch all straps at reset release.
// - First mode setting: sideband off, speed indicators.
// - Second mode setting: sideband slave, speed indicators.
// - Speed indicator: float idle, 0 USB2, 1 5G.
// - Fifth setting: charge indicators; others reserved.
// - Charge indicator floats when charging disabled.
// - Charge indicator: 0 handshake done, else 1.
// - Port disabled only when both straps high.
// - Strap disable also disables 5G side.
// - Fixed-port strap decodes six port counts.
// - Charging strap decodes six port counts.
// - GPIO input with pulls, or driven output.
// - Reset low holds standby, all state cleared.
// - Reset high runs boot stages to hub.
// - Probe ROM signature; found, run external.
// - No signature or strap: internal default load.
// - ROM reads single or dual, mode 0/3.
// - Load defaults, then strap overrides.
// - Second setting plus pull-ups enters SoC stage.
// - SoC stage waits forever for register write.
// - Merge, idle without VBUS, then detect/connect.
// - Connect held until VBUS function drops.
`timescale 1ns/1ps
module hsbs_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Configuration straps, asynchronous pins
  input  wire logic [2:0]  mode_strap_code,
  input  wire logic [2:0]  fixed_port_count_strap,
  input  wire logic [2:0]  charging_port_count_strap,
  input  wire logic [6:0]  port_dplus_disable_strap,
  input  wire logic [6:0]  port_dminus_disable_strap,
  input  wire logic        spi_boot_strap,
  // Sideband bus pull sensing and slave events
  input  wire logic        sideband_data_pin_pullup,
  input  wire logic        sideband_clock_pin_pullup,
  input  wire logic        sideband_reg_wr,
  input  wire logic [7:0]  sideband_reg_addr,
  output logic             sideband_enable,
  // Port status from the hub core
  input  wire logic [6:0]  port_connected,
  input  wire logic [6:0]  port_superspeed,
  input  wire logic [6:0]  charge_handshake_done,
  // Programmable indicator pins
  output logic      [6:0]  indicator_out,
  output logic      [6:0]  indicator_oe,
  // General purpose pins and their configuration
  input  wire logic [27:0] gpio_cfg_output,
  input  wire logic [27:0] gpio_cfg_level,
  input  wire logic [27:0] gpio_cfg_pull_en,
  input  wire logic [27:0] gpio_cfg_pull_up,
  input  wire logic [27:0] gpio_in,
  output logic      [27:0] gpio_out,
  output logic      [27:0] gpio_oe,
  output logic      [27:0] gpio_pullup_en,
  output logic      [27:0] gpio_pulldown_en,
  output logic      [27:0] gpio_in_sync,
  // Serial ROM
  input  wire logic        spi_dual_en,
  input  wire logic        spi_mode3,
  input  wire logic        spi_io0_in,
  input  wire logic        spi_io1_in,
  output logic             spi_sclk,
  output logic             spi_ce_n,
  output logic             spi_io0_out,
  output logic             spi_io0_oe,
  output logic             ext_boot,
  output logic      [23:0] ext_exec_addr,
  // Boot sequencing
  input  wire logic        vbus_present,
  input  wire logic        charger_detect_done,
  output logic      [9:0]  boot_stage,
  output logic             hub_suspend,
  output logic             charger_detect_start,
  output logic             usb_connect,
  // Resulting configuration
  output logic      [6:0]  port_disable,
  output logic      [6:0]  ss_port_disable,
  output logic      [6:0]  fixed_port_mask,
  output logic      [6:0]  charge_port_mask
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [56:0] pin_sync;
  logic [2:0]  s_mode;
  logic [2:0]  s_fixed;
  logic [2:0]  s_charge;
  logic [6:0]  s_dp;
  logic [6:0]  s_dm;
  logic        s_spi_boot;
  logic        s_sb_data;
  logic        s_sb_clk;
  logic        s_vbus;
  logic        s_io0;
  logic        s_io1;

  hsbs_sync #(.WIDTH(hsbs_pkg::SYNC_W)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({mode_strap_code, fixed_port_count_strap, charging_port_count_strap,
                port_dplus_disable_strap, port_dminus_disable_strap, spi_boot_strap,
                sideband_data_pin_pullup, sideband_clock_pin_pullup, vbus_present,
                gpio_in, spi_io0_in, spi_io1_in}),
    .sync_out (pin_sync)
  );

  // Unpack the synchronised pins.
  assign {s_mode, s_fixed, s_charge, s_dp, s_dm, s_spi_boot, s_sb_data, s_sb_clk,
          s_vbus, gpio_in_sync, s_io0, s_io1} = pin_sync;

  // ----------------------------------------------------------------
  // Strap latch
  // ----------------------------------------------------------------
  hsbs_pkg::hsbs_state_t state;
  hsbs_pkg::hsbs_state_t next_state;
  logic [1:0] init_cnt;
  logic       straps_latched;
  logic [2:0] l_mode;
  logic [2:0] l_fixed;
  logic [2:0] l_charge;
  logic [6:0] l_dp;
  logic [6:0] l_dm;
  logic       l_spi_boot;
  logic       init_done;

  // The pipes hold reset zeros until they refill, so the capture waits out their depth.
  assign init_done = (init_cnt == 2'(hsbs_pkg::SYNC_DEPTH));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt <= 2'h0;
    end else if (state == hsbs_pkg::ST_INIT && !init_done) begin
      init_cnt <= init_cnt + 2'h1;
    end
  end

  // Capture happens once; only a fresh reset opens it again.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      straps_latched <= 1'b0;
      l_mode         <= 3'h0;
      l_fixed        <= 3'h0;
      l_charge       <= 3'h0;
      l_dp           <= 7'h00;
      l_dm           <= 7'h00;
      l_spi_boot     <= 1'b0;
    end else if (init_done && !straps_latched) begin
      straps_latched <= 1'b1;
      l_mode         <= s_mode;
      l_fixed        <= s_fixed;
      l_charge       <= s_charge;
      l_dp           <= s_dp;
      l_dm           <= s_dm;
      l_spi_boot     <= s_spi_boot;
    end
  end

  // Six-way count strap to port mask; unused codes select no ports.
  function automatic logic [6:0] count_mask(input logic [2:0] code);
    case (code)
      hsbs_pkg::CODE_200K_PD: count_mask = hsbs_pkg::MASK_NONE;
      hsbs_pkg::CODE_200K_PU: count_mask = hsbs_pkg::MASK_P1;
      hsbs_pkg::CODE_10K_PD:  count_mask = hsbs_pkg::MASK_P12;
      hsbs_pkg::CODE_10K_PU:  count_mask = hsbs_pkg::MASK_P13;
      hsbs_pkg::CODE_10R_PD:  count_mask = hsbs_pkg::MASK_P14;
      hsbs_pkg::CODE_10R_PU:  count_mask = hsbs_pkg::MASK_P17;
      default:                count_mask = hsbs_pkg::MASK_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Serial ROM signature probe
  // ----------------------------------------------------------------
  logic        spi_busy;
  logic        spi_done;
  logic [1:0]  half_cnt;
  logic        sclk_phase;
  logic [6:0]  clk_cnt;
  logic [31:0] tx_shift;
  logic [31:0] rx_shift;
  logic        dual_l;
  logic        mode3_l;
  logic [6:0]  data_start;
  logic [6:0]  total_clks;
  logic        half_tick;
  logic        in_data;

  assign data_start = dual_l ? hsbs_pkg::SPI_HDR_CLKS + hsbs_pkg::SPI_DUMMY
                             : hsbs_pkg::SPI_HDR_CLKS;
  assign total_clks = data_start + (dual_l ? hsbs_pkg::SPI_DATA_2B : hsbs_pkg::SPI_DATA_1B);
  assign half_tick  = (half_cnt == 2'(hsbs_pkg::SPI_HALF_CYC - 1));
  assign in_data    = (clk_cnt >= data_start);

  // Each ROM clock is a low half then a high half; mode 3 differs only in idle level.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_busy   <= 1'b0;
      spi_done   <= 1'b0;
      half_cnt   <= 2'h0;
      sclk_phase <= 1'b0;
      clk_cnt    <= 7'h00;
      tx_shift   <= 32'h00000000;
      rx_shift   <= 32'h00000000;
      dual_l     <= 1'b0;
      mode3_l    <= 1'b0;
    end else if (state == hsbs_pkg::ST_PROBE && !spi_busy && !spi_done) begin
      spi_busy   <= 1'b1;
      dual_l     <= spi_dual_en;
      mode3_l    <= spi_mode3;
      half_cnt   <= 2'h0;
      sclk_phase <= 1'b0;
      clk_cnt    <= 7'h00;
      tx_shift   <= {spi_dual_en ? hsbs_pkg::SPI_CMD_DUAL : hsbs_pkg::SPI_CMD_READ,
                     hsbs_pkg::SPI_SIG_ADDR};
    end else if (spi_busy) begin
      half_cnt <= half_tick ? 2'h0 : half_cnt + 2'h1;
      if (half_tick) begin
        sclk_phase <= ~sclk_phase;
        if (sclk_phase) begin
          // Falling edge: synchronised data now shows the level at the rising edge.
          if (in_data) begin
            rx_shift <= dual_l ? {rx_shift[29:0], s_io1, s_io0} : {rx_shift[30:0], s_io1};
          end
          tx_shift <= {tx_shift[30:0], 1'b0};
          clk_cnt  <= clk_cnt + 7'h01;
          if (clk_cnt + 7'h01 == total_clks) begin
            spi_busy <= 1'b0;
            spi_done <= 1'b1;
          end
        end
      end
    end
  end

  // ROM pins; io0 turns round to input for the dual data phase.
  always_comb begin
    spi_ce_n    = ~spi_busy;
    spi_sclk    = spi_busy ? sclk_phase : mode3_l;
    spi_io0_out = tx_shift[31];
    spi_io0_oe  = spi_busy && !(dual_l && in_data);
  end

  // ----------------------------------------------------------------
  // Boot stage sequencer
  // ----------------------------------------------------------------
  logic soc_done;

  assign soc_done = sideband_reg_wr && (sideband_reg_addr == hsbs_pkg::SOC_DONE_REG);

  always_comb begin
    next_state = state;
    case (state)
      hsbs_pkg::ST_INIT: begin
        if (straps_latched) begin
          next_state = l_spi_boot ? hsbs_pkg::ST_PROBE : hsbs_pkg::ST_CFG_RD;
        end
      end
      hsbs_pkg::ST_PROBE: begin
        if (spi_done) begin
          next_state = (rx_shift == hsbs_pkg::SPI_SIGNATURE) ? hsbs_pkg::ST_EXT
                                                             : hsbs_pkg::ST_CFG_RD;
        end
      end
      hsbs_pkg::ST_EXT:    next_state = hsbs_pkg::ST_EXT;
      hsbs_pkg::ST_CFG_RD: next_state = hsbs_pkg::ST_STRAP;
      hsbs_pkg::ST_STRAP: begin
        if (l_mode == hsbs_pkg::indicators_sideband_slave_setting && s_sb_data && s_sb_clk) begin
          next_state = hsbs_pkg::ST_SOC_CFG;
        end else begin
          next_state = hsbs_pkg::ST_MERGE;
        end
      end
      hsbs_pkg::ST_SOC_CFG: begin
        if (soc_done) begin
          next_state = hsbs_pkg::ST_MERGE;
        end
      end
      hsbs_pkg::ST_MERGE: next_state = hsbs_pkg::ST_IDLE;
      hsbs_pkg::ST_IDLE: begin
        if (s_vbus) begin
          next_state = (charge_port_mask != 7'h00) ? hsbs_pkg::ST_CHARGER_DETECT_STAGE
                                                   : hsbs_pkg::ST_CONNECT;
        end
      end
      hsbs_pkg::ST_CHARGER_DETECT_STAGE: begin
        if (charger_detect_done) begin
          next_state = hsbs_pkg::ST_CONNECT;
        end
      end
      hsbs_pkg::ST_CONNECT: begin
        if (!s_vbus) begin
          next_state = hsbs_pkg::ST_IDLE;
        end
      end
      default: next_state = hsbs_pkg::ST_INIT;
    endcase
  end

  // Reset low parks everything in the first stage with nothing kept.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= hsbs_pkg::ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Stage flags seen by the rest of the hub.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_boot             <= 1'b0;
      ext_exec_addr        <= 24'h000000;
      hub_suspend          <= 1'b0;
      charger_detect_start <= 1'b0;
      usb_connect          <= 1'b0;
    end else begin
      ext_boot             <= (next_state == hsbs_pkg::ST_EXT);
      ext_exec_addr        <= hsbs_pkg::SPI_EXEC_ADDR;
      hub_suspend          <= (next_state == hsbs_pkg::ST_IDLE) && !s_vbus;
      charger_detect_start <= (next_state == hsbs_pkg::ST_CHARGER_DETECT_STAGE);
      usb_connect          <= (next_state == hsbs_pkg::ST_CONNECT);
    end
  end

  assign boot_stage = state;

  // ----------------------------------------------------------------
  // Configuration: defaults, then strap overrides
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_disable     <= hsbs_pkg::DEF_PORT_DISABLE;
      ss_port_disable  <= hsbs_pkg::DEF_PORT_DISABLE;
      fixed_port_mask  <= hsbs_pkg::DEF_FIXED_MASK;
      charge_port_mask <= hsbs_pkg::DEF_CHARGE_MASK;
      sideband_enable  <= 1'b0;
    end else if (state == hsbs_pkg::ST_CFG_RD) begin
      port_disable     <= hsbs_pkg::DEF_PORT_DISABLE;
      ss_port_disable  <= hsbs_pkg::DEF_PORT_DISABLE;
      fixed_port_mask  <= hsbs_pkg::DEF_FIXED_MASK;
      charge_port_mask <= hsbs_pkg::DEF_CHARGE_MASK;
    end else if (state == hsbs_pkg::ST_STRAP) begin
      port_disable     <= l_dp & l_dm;
      ss_port_disable  <= l_dp & l_dm;
      fixed_port_mask  <= count_mask(l_fixed);
      charge_port_mask <= count_mask(l_charge);
      sideband_enable  <= (l_mode == hsbs_pkg::indicators_sideband_slave_setting);
    end
  end

  // ----------------------------------------------------------------
  // Programmable indicator pins
  // ----------------------------------------------------------------
  // Indicators stay released until the straps are latched, so a board never sees a glitch.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      indicator_out <= 7'h00;
      indicator_oe  <= 7'h00;
    end else if (!straps_latched) begin
      indicator_out <= 7'h00;
      indicator_oe  <= 7'h00;
    end else begin
      case (l_mode)
        hsbs_pkg::indicators_no_sideband_setting,
        hsbs_pkg::indicators_sideband_slave_setting: begin
          indicator_oe  <= port_connected;
          indicator_out <= port_superspeed;
        end
        hsbs_pkg::charge_indicator_setting: begin
          indicator_oe  <= charge_port_mask;
          indicator_out <= ~charge_handshake_done;
        end
        default: begin
          indicator_oe  <= 7'h00;
          indicator_out <= 7'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // General purpose pins
  // ----------------------------------------------------------------
  // Pulls apply only to inputs; a driven pin never fights its own pull.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_out         <= 28'h0000000;
      gpio_oe          <= 28'h0000000;
      gpio_pullup_en   <= 28'h0000000;
      gpio_pulldown_en <= 28'h0000000;
    end else begin
      gpio_oe          <= gpio_cfg_output;
      gpio_out         <= gpio_cfg_output & gpio_cfg_level;
      gpio_pullup_en   <= ~gpio_cfg_output & gpio_cfg_pull_en & gpio_cfg_pull_up;
      gpio_pulldown_en <= ~gpio_cfg_output & gpio_cfg_pull_en & ~gpio_cfg_pull_up;
    end
  end

endmodule

// file: dv/hsbs_top_asserts.sv
// Assertions bound to hsbs_top.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ps
module hsbs_top_asserts (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Watched signals
  input wire logic [9:0] boot_stage,
  input wire logic       sideband_reg_wr,
  input wire logic [7:0] sideband_reg_addr,
  input wire logic       sideband_enable,
  input wire logic [6:0] port_connected,
  input wire logic [6:0] port_superspeed,
  input wire logic [6:0] indicator_out,
  input wire logic [6:0] indicator_oe,
  input wire logic       charger_detect_done,
  input wire logic [6:0] charge_port_mask,
  input wire logic       hub_suspend,
  input wire logic       charger_detect_start,
  input wire logic       usb_connect,
  input wire logic [6:0] port_disable,
  input wire logic [6:0] ss_port_disable,
  input wire logic [6:0] fixed_port_mask
);
  // ----------
  // Properties
  // ----------
  // One domain, so clock and reset are set once.
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_soc_hold;
    boot_stage == 10'h020 && !(sideband_reg_wr && sideband_reg_addr == 8'hff)
      |=> boot_stage == 10'h020;
  endproperty
  a_soc_hold: assert property (p_soc_hold) else $error("soc stage left early");
  property p_soc_exit;
    boot_stage == 10'h020 && sideband_reg_wr && sideband_reg_addr == 8'hff
      |=> boot_stage == 10'h040;
  endproperty
  a_soc_exit: assert property (p_soc_exit) else $error("soc stage not ended");
  property p_ind_spd;
    sideband_enable |=> indicator_oe == $past(port_connected)
      && indicator_out == $past(port_superspeed);
  endproperty
  a_ind_spd: assert property (p_ind_spd) else $error("speed indicator wrong");
  property p_hold;
    (boot_stage & 10'h380) != 10'h000 |=> $stable(port_disable)
      && $stable(fixed_port_mask) && $stable(charge_port_mask);
  endproperty
  a_hold: assert property (p_hold) else $error("latched config moved");
  property p_chg_entry;
    $past(boot_stage) == 10'h080 && boot_stage == 10'h100 |-> charge_port_mask != 7'h00;
  endproperty
  a_chg_entry: assert property (p_chg_entry) else $error("charger stage unneeded");
  property p_chg_conn;
    boot_stage == 10'h100 && charger_detect_done |=> boot_stage == 10'h200;
  endproperty
  a_chg_conn: assert property (p_chg_conn) else $error("connect not entered");
  property p_flags;
    usb_connect == (boot_stage == 10'h200) && charger_detect_start == (boot_stage == 10'h100);
  endproperty
  a_flags: assert property (p_flags) else $error("stage flags wrong");
  property p_suspend;
    hub_suspend |-> boot_stage == 10'h080;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend outside idle");
  property p_ss_dis;
    ss_port_disable == port_disable;
  endproperty
  a_ss_dis: assert property (p_ss_dis) else $error("5G disable differs");
endmodule

bind hsbs_top hsbs_top_asserts u_chk (.*);

// file: dv/hsbs_soc_model.sv
// External SoC model for the SoC stage.
// Assumes the stage code is visible; writes are pulses.
`timescale 1ns/1ps
module hsbs_soc_model (
  // Clock and stage
  input  wire logic       ref_clk,
  input  wire logic [9:0] boot_stage,
  // Register write events
  output logic            sideband_reg_wr = 1'b0,
  output logic      [7:0] sideband_reg_addr = 8'h00
);
  logic [4:0] cnt = 5'h00;

  // A stray write comes first; only the late write to 0xff closes the stage.
  always_ff @(posedge ref_clk) begin
    cnt <= (boot_stage == 10'h020) ? cnt + 5'h01 : 5'h00;
    sideband_reg_wr <= (cnt == 5'h04) || (cnt == 5'h14);
    sideband_reg_addr <= (cnt == 5'h14) ? 8'hff : {3'h0, cnt};
  end
endmodule

// file: dv/test_hub_strap_boot_sequencer.sv
// Self-checking bench for hsbs_top.
// Assumes a 200 MHz clock and a blank serial ROM.
`timescale 1ns/1ps
module test_hub_strap_boot_sequencer;
  logic ref_clk = 0, rst_n = 0, vbus_present = 0, charger_detect_done = 0, spi_boot_strap = 0;
  logic sideband_data_pin_pullup = 1, sideband_clock_pin_pullup = 1, sideband_reg_wr;
  logic sideband_enable, hub_suspend, charger_detect_start, usb_connect, seen_soc = 0, ext_boot;
  logic [2:0] mode_strap_code = 0, fixed_port_count_strap = 0, charging_port_count_strap = 0;
  logic [6:0] port_dplus_disable_strap = 0, port_dminus_disable_strap = 0, port_connected = 0;
  logic [6:0] port_superspeed = 0, charge_handshake_done = 0, indicator_out, indicator_oe;
  logic [6:0] port_disable, ss_port_disable, fixed_port_mask, charge_port_mask;
  logic [7:0] sideband_reg_addr;
  logic [9:0] boot_stage;
  logic [27:0] gpio_cfg_output = 0, gpio_cfg_level = 0, gpio_cfg_pull_en = 0;
  logic [27:0] gpio_cfg_pull_up = 0, gpio_in = 0, gpio_out, gpio_oe, gpio_pullup_en;
  logic [27:0] gpio_pulldown_en, gpio_in_sync;
  logic [6:0] mt [8] = '{7'h00, 7'h01, 7'h03, 7'h07, 7'h0f, 7'h7f, 7'h00, 7'h00};
  int failures = 0, n_compared = 0;

  // ----------
  // Clock, design and partner
  // ----------
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  hsbs_top dut (.ref_clk, .rst_n, .mode_strap_code, .fixed_port_count_strap,
    .charging_port_count_strap, .port_dplus_disable_strap, .port_dminus_disable_strap,
    .spi_boot_strap, .sideband_data_pin_pullup, .sideband_clock_pin_pullup,
    .sideband_reg_wr, .sideband_reg_addr, .sideband_enable, .port_connected,
    .port_superspeed, .charge_handshake_done, .indicator_out, .indicator_oe,
    .gpio_cfg_output, .gpio_cfg_level, .gpio_cfg_pull_en, .gpio_cfg_pull_up, .gpio_in,
    .gpio_out, .gpio_oe, .gpio_pullup_en, .gpio_pulldown_en, .gpio_in_sync,
    .spi_dual_en(1'b0), .spi_mode3(1'b0), .spi_io0_in(1'b0), .spi_io1_in(1'b0),
    .spi_sclk(), .spi_ce_n(), .spi_io0_out(), .spi_io0_oe(), .ext_boot, .ext_exec_addr(),
    .vbus_present, .charger_detect_done, .boot_stage, .hub_suspend, .charger_detect_start,
    .usb_connect, .port_disable, .ss_port_disable, .fixed_port_mask, .charge_port_mask);
  hsbs_soc_model soc (.ref_clk, .boot_stage, .sideband_reg_wr, .sideband_reg_addr);

  // Notes a visit to the SoC stage since the last reset.
  always @(negedge ref_clk) if (boot_stage === 10'h020) seen_soc = 1;

  // ----------
  // Tasks
  // ----------
  task automatic chk(string n, logic [55:0] e, logic [55:0] g);
    n_compared++;
    if (e !== g) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // Bounded wait at falling edges.
  task automatic wait_st(logic [9:0] v);
    for (int i = 0; i < 300 && boot_stage !== v; i++) @(negedge ref_clk);
    chk("boot_stage", v, boot_stage);
  endtask

  task automatic end_sim;
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One boot, then checks.
  task automatic run(logic [2:0] m, logic pu);
    logic [2:0] c;
    logic [6:0] eo;
    c = 3'h7 - m;
    @(posedge ref_clk);
    rst_n <= 0;
    {mode_strap_code, fixed_port_count_strap, charging_port_count_strap} <= {m, m, c};
    {port_dplus_disable_strap, port_dminus_disable_strap} <= {7'h55, 7'h33};
    sideband_data_pin_pullup <= pu;
    spi_boot_strap <= &m;
    repeat (11) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("standby", 17'h00080, {boot_stage, indicator_oe});
    seen_soc = 0;
    @(posedge ref_clk);
    rst_n <= 1;
    repeat (4) @(posedge ref_clk);
    // Later strap changes must be ignored.
    {mode_strap_code, fixed_port_count_strap, charging_port_count_strap} <= ~{m, m, c};
    {port_dplus_disable_strap, port_dminus_disable_strap} <= 14'h3fff;
    wait_st(10'h080);
    chk("seen_soc", m == 3'h1 && pu, seen_soc);
    chk("fixed_port_mask", mt[m], fixed_port_mask);
    chk("charge_port_mask", mt[c], charge_port_mask);
    chk("port_disable", 14'h0891, {port_disable, ss_port_disable});
    chk("sideband_enable", m == 3'h1, sideband_enable);
    chk("suspend_ext", 2'h2, {hub_suspend, ext_boot});
    @(posedge ref_clk);
    {port_connected, port_superspeed, charge_handshake_done} <= {7'h5a, 7'h0f, 7'h33};
    vbus_present <= 1;
    repeat (2) @(negedge ref_clk);
    eo = (m <= 3'h1) ? 7'h5a : (m == 3'h4) ? mt[c] : 7'h00;
    chk("indicator_oe", eo, indicator_oe);
    chk("indicator_out", eo & ((m <= 3'h1) ? 7'h0f : 7'h4c), indicator_out & indicator_oe);
    if (mt[c] != 7'h00) begin
      wait_st(10'h100);
      @(posedge ref_clk);
      charger_detect_done <= 1;
    end
    wait_st(10'h200);
    chk("usb_connect", 1, usb_connect);
    @(posedge ref_clk);
    {charger_detect_done, vbus_present} <= 2'h0;
    wait_st(10'h080);
  endtask

  // ----------
  // Tests and watchdog
  // ----------
  initial begin
    for (int k = 0; k < 9; k++) run(k == 8 ? 3'h1 : 3'(k), k != 8);
    @(posedge ref_clk);
    {gpio_cfg_output, gpio_cfg_level} <= {28'h00000f0, 28'h0000030};
    {gpio_cfg_pull_en, gpio_cfg_pull_up, gpio_in} <= {28'h0000f0f, 28'h0000303, 28'h5a5a5a5};
    repeat (3) @(negedge ref_clk);
    chk("gpio_oe", 28'h00000f0, gpio_oe);
    chk("gpio_out", 28'h0000030, gpio_out & gpio_oe);
    chk("gpio_pulls", 56'h00003030000c0c, {gpio_pullup_en, gpio_pulldown_en});
    chk("gpio_in_sync", 28'h5a5a5a5, gpio_in_sync);
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim;
  end
endmodule
